// File: logic/tscw_pkg.sv
// shared constants and types for the transceiver serial control word link
// Operation
// - shift data in MSB first on falling clock
// - select low 20 ns before first rise
// - rising select copies shift register to latch
// - 20 ns from last fall to select rise
// - 16-bit word, bit 15 gain reduce
// - bit 12 disables transmit, powers on high
// - host clears bit 12 under pin control (host has no pin control: bit 12 goes out as software writes it)
// - host keeps test bits 10, 9 low
// - bits 11, 8, 7 pick analog source
// - bit 4 selects high LO buffer power
// - bit 3 selects high transmit buffer power
// - bits 2..0 reduce power, power on high
// - serial clock phases at least 10 ns
package tscw_pkg;

  localparam int          WORD_W           = 16;
  localparam logic [15:0] WORD_RESET       = 16'h1807;
  localparam logic [15:0] TEST_BITS_MASK   = 16'h0600;

  // bit positions of the control word
  localparam int BIT_LNA_GAIN_REDUCE   = 15;
  localparam int BIT_TX_POWER_DISABLE  = 12;
  localparam int BIT_ANALOG_SEL2       = 11;
  localparam int BIT_TEST_HI           = 10;
  localparam int BIT_TEST_LO           = 9;
  localparam int BIT_ANALOG_SEL1       = 8;
  localparam int BIT_ANALOG_SEL0       = 7;
  localparam int BIT_BIG_DIV_DISABLE   = 6;
  localparam int BIT_SIXTEEN_DIV_DIS   = 5;
  localparam int BIT_LO_BUF_HIGH       = 4;
  localparam int BIT_TX_BUF_HIGH       = 3;
  localparam int BIT_TX_REDUCE_MSB     = 2;

  typedef enum logic [2:0] {
    TSCW_SRC_TX_DET      = 3'h0,
    TSCW_SRC_TX_REF      = 3'h1,
    TSCW_SRC_LO_DET      = 3'h2,
    TSCW_SRC_LO_REF      = 3'h3,
    TSCW_SRC_TEMP        = 3'h4,
    TSCW_SRC_TEST1       = 3'h5,
    TSCW_SRC_TEST2       = 3'h6,
    TSCW_SRC_TEST2_ALT   = 3'h7
  } tscw_src_type;

  // timing, in ns, and in system clock cycles (least times round up)
  localparam int SYS_PERIOD_NS  = 40;
  localparam int LEAD_NS        = 20;
  localparam int LAG_NS         = 20;
  localparam int HALF_NS        = 10;
  localparam int LEAD_CYC       = (LEAD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int LAG_CYC        = (LAG_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int HALF_CYC       = (HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // host register map
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  REG_WORD        = 8'h00;
  localparam logic [7:0]  REG_CMD         = 8'h04;
  localparam logic [7:0]  REG_STATUS      = 8'h08;
  localparam logic [7:0]  REG_SENT        = 8'h0c;
  localparam int          CMD_START_BIT   = 0;
  localparam int          STAT_BUSY_BIT   = 1 - 1;
  localparam int          STAT_DONE_BIT   = 1;

endpackage

// File: logic/tscw_link_if.sv
// three-wire serial link between host and transceiver control port
`timescale 1ns/100ps
interface tscw_link_if;
  logic sclk;
  logic sdata;
  logic sel_n;

  modport device (
    input sclk,
    input sdata,
    input sel_n
  );

  modport host (
    output sclk,
    output sdata,
    output sel_n
  );
endinterface

// File: logic/tscw_device.sv
// transceiver side: serial shift register and control latch
`timescale 1ns/100ps
module tscw_device (
  // link
  tscw_link_if.device                  link,
  // reset and freeze
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  // decoded controls
  output logic [15:0]                  control_word_o,
  output logic                         lna_gain_reduce_o,
  output logic                         tx_power_disable_o,
  output logic [2:0]                   analog_sel_o,
  output tscw_pkg::tscw_src_type       analog_monitor_out_o,
  output logic                         test_bits_set_o,
  output logic                         big_divider_disable_o,
  output logic                         sixteen_divider_disable_o,
  output logic                         lo_buffer_high_power_o,
  output logic                         tx_buffer_high_power_o,
  output logic [2:0]                   tx_power_reduce_o
);

  logic [15:0] shift_reg;
  logic [15:0] latch_reg;

  // ce_i must be quasi-static: it is sampled on link edges without a synchroniser
  always_ff @(negedge link.sclk or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_reg <= 16'h0000;
    end else if (ce_i && !link.sel_n) begin
      shift_reg <= {shift_reg[14:0], link.sdata};
    end
  end

  // select acts as the latch clock; only the last 16 bits shifted survive
  always_ff @(posedge link.sel_n or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_reg <= tscw_pkg::WORD_RESET;
    end else if (ce_i) begin
      latch_reg <= shift_reg;
    end
  end

  assign control_word_o            = latch_reg;
  assign lna_gain_reduce_o         = latch_reg[tscw_pkg::BIT_LNA_GAIN_REDUCE];
  assign tx_power_disable_o        = latch_reg[tscw_pkg::BIT_TX_POWER_DISABLE];
  assign analog_sel_o              = {latch_reg[tscw_pkg::BIT_ANALOG_SEL2],
                                      latch_reg[tscw_pkg::BIT_ANALOG_SEL1],
                                      latch_reg[tscw_pkg::BIT_ANALOG_SEL0]};
  assign analog_monitor_out_o      = tscw_pkg::tscw_src_type'(analog_sel_o);
  // test bits have no function here, only flagged for the bench
  assign test_bits_set_o           = |(latch_reg & tscw_pkg::TEST_BITS_MASK);
  assign big_divider_disable_o     = latch_reg[tscw_pkg::BIT_BIG_DIV_DISABLE];
  assign sixteen_divider_disable_o = latch_reg[tscw_pkg::BIT_SIXTEEN_DIV_DIS];
  assign lo_buffer_high_power_o    = latch_reg[tscw_pkg::BIT_LO_BUF_HIGH];
  assign tx_buffer_high_power_o    = latch_reg[tscw_pkg::BIT_TX_BUF_HIGH];
  assign tx_power_reduce_o         = latch_reg[tscw_pkg::BIT_TX_REDUCE_MSB:0];

endmodule

// File: logic/tscw_host.sv
// host side: register port and serial master that sends one control word
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
module tscw_host #(
  parameter int LEAD_CYC = tscw_pkg::LEAD_CYC,
  parameter int LAG_CYC  = tscw_pkg::LAG_CYC,
  parameter int HALF_CYC = tscw_pkg::HALF_CYC
) (
  // clock, reset, freeze
  input  wire logic                    sys_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    ce_i,
  // register port
  input  wire logic [7:0]              addr_i,
  input  wire logic [31:0]             wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic [31:0]                  rdata_o,
  // link
  tscw_link_if.host                    link
);

  typedef enum logic [2:0] {
    TSCW_IDLE,
    TSCW_LEAD,
    TSCW_HIGH,
    TSCW_LOW,
    TSCW_LAG
  } tscw_state_type;

  tscw_state_type state;
  logic [15:0]    word_reg;
  logic [15:0]    sent_reg;
  logic [15:0]    tx_shift;
  logic [3:0]     bits_left;
  logic [7:0]     wait_cnt;
  logic           done_flag;
  logic           sclk_q;
  logic           sdata_q;
  logic           sel_n_q;
  logic           start_req;
  logic           frame_end;
  logic           wait_zero;
  logic           next_bit;
  logic           last_low;
  logic           clk_rise;
  logic           clk_fall;

  assign wait_zero = wait_cnt == 8'h00;
  assign start_req = ce_i && wr_i && addr_i == tscw_pkg::REG_CMD && wdata_i[tscw_pkg::CMD_START_BIT]
                     && state == TSCW_IDLE;
  assign frame_end = ce_i && state == TSCW_LAG && wait_zero;
  // a low phase ends either by raising the clock for the next bit or by entering the lag
  assign next_bit  = ce_i && state == TSCW_LOW && wait_zero && bits_left != 4'h0;
  assign last_low  = ce_i && state == TSCW_LOW && wait_zero && bits_left == 4'h0;
  assign clk_rise  = (ce_i && state == TSCW_LEAD && wait_zero) || next_bit;
  assign clk_fall  = ce_i && state == TSCW_HIGH && wait_zero;

  // test bits forced low so no software slip can upset the transceiver
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      word_reg <= tscw_pkg::WORD_RESET;
    end else if (ce_i && wr_i && addr_i == tscw_pkg::REG_WORD) begin
      word_reg <= wdata_i[15:0] & ~tscw_pkg::TEST_BITS_MASK;
    end
  end

  // done is sticky; a frame end in the clearing cycle wins
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_flag <= 1'b0;
    end else if (frame_end) begin
      done_flag <= 1'b1;
    end else if (ce_i && wr_i && addr_i == tscw_pkg::REG_STATUS && wdata_i[tscw_pkg::STAT_DONE_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          tscw_pkg::REG_WORD:   rdata_o <= {16'h0000, word_reg};
          tscw_pkg::REG_STATUS: rdata_o <= {30'h0000_0000, done_flag, state != TSCW_IDLE};
          tscw_pkg::REG_SENT:   rdata_o <= {16'h0000, sent_reg};
          default:              rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // serial master, split by concern; every link pin comes straight from a flop
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= TSCW_IDLE;
    end else if (ce_i) begin
      case (state)
        TSCW_IDLE: begin
          if (start_req) begin
            state <= TSCW_LEAD;
          end
        end
        TSCW_LEAD: begin
          if (wait_zero) begin
            state <= TSCW_HIGH;
          end
        end
        TSCW_HIGH: begin
          if (wait_zero) begin
            state <= TSCW_LOW;
          end
        end
        TSCW_LOW: begin
          if (last_low) begin
            state <= TSCW_LAG;
          end else if (next_bit) begin
            state <= TSCW_HIGH;
          end
        end
        TSCW_LAG: begin
          if (wait_zero) begin
            state <= TSCW_IDLE;
          end
        end
        default: begin
          state <= TSCW_IDLE;
        end
      endcase
    end
  end

  // one down-count per phase, reloaded as each phase begins
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_cnt <= 8'h00;
    end else if (start_req) begin
      wait_cnt <= 8'(LEAD_CYC - 1);
    end else if (last_low) begin
      wait_cnt <= 8'(LAG_CYC - 1);
    end else if (clk_rise || clk_fall) begin
      wait_cnt <= 8'(HALF_CYC - 1);
    end else if (ce_i && state != TSCW_IDLE && !wait_zero) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // bits_left counts the bits still to go after the one on the wire
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_shift  <= 16'h0000;
      bits_left <= 4'h0;
    end else if (start_req) begin
      tx_shift  <= {word_reg[14:0], 1'b0};
      bits_left <= 4'(tscw_pkg::WORD_W - 1);
    end else if (next_bit) begin
      tx_shift  <= {tx_shift[14:0], 1'b0};
      bits_left <= bits_left - 4'h1;
    end
  end

  // last word launched, for software to read back
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sent_reg <= tscw_pkg::WORD_RESET;
    end else if (start_req) begin
      sent_reg <= word_reg;
    end
  end

  // clock idles low between frames
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_q <= 1'b0;
    end else if (clk_rise) begin
      sclk_q <= 1'b1;
    end else if (clk_fall) begin
      sclk_q <= 1'b0;
    end
  end

  // first bit moves as select falls, the rest with the rising clock, a full phase clear of each sampling fall
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sdata_q <= 1'b0;
    end else if (start_req) begin
      sdata_q <= word_reg[15];
    end else if (next_bit) begin
      sdata_q <= tx_shift[15];
    end else if (frame_end) begin
      sdata_q <= 1'b0;
    end
  end

  // select brackets the frame; the lag count keeps it low past the last fall
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel_n_q <= 1'b1;
    end else if (start_req) begin
      sel_n_q <= 1'b0;
    end else if (frame_end) begin
      sel_n_q <= 1'b1;
    end
  end

  assign link.sclk  = sclk_q;
  assign link.sdata = sdata_q;
  assign link.sel_n = sel_n_q;

endmodule

// File: testbench/tscw_link_chk.sv
// assertions on the three-wire link between host and transceiver ends
`timescale 1ns/100ps
module tscw_link_chk (
  // system clock and reset
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  // link wires
  input  wire logic sclk_i,
  input  wire logic sdata_i,
  input  wire logic sel_n_i
);
  logic [4:0] nfall;
  logic       sclk_q;

  // falls seen so far in the current frame
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      nfall  <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
      if (sel_n_i) nfall <= 5'h00;
      else if (sclk_q && !sclk_i) nfall <= nfall + 5'h01;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_lead_time: assert property ($rose(sclk_i) |-> !sel_n_i && $past(!sel_n_i))
    else $error("clock rose without select lead");
  a_high_phase: assert property ($rose(sclk_i) |=> $fell(sclk_i) && !sel_n_i)
    else $error("clock high phase wrong or select dropped");
  a_lag_time: assert property ($rose(sel_n_i) |-> !sclk_i && !$past(sclk_i))
    else $error("select rose too soon after last fall");
  a_bit_count: assert property ($rose(sel_n_i) |-> nfall == 5'd16)
    else $error("frame did not carry sixteen bits");
  a_data_setup: assert property ($fell(sclk_i) |-> $stable(sdata_i))
    else $error("data moved at the sampling fall");
  a_sclk_idle: assert property (sel_n_i |-> !sclk_i)
    else $error("clock active while deselected");
  a_test_bits: assert property ($fell(sclk_i) && (nfall == 5'd5 || nfall == 5'd6) |-> !sdata_i)
    else $error("test bit sent high");
  a_select_start: assert property ($fell(sel_n_i) |-> !sclk_i && nfall == 5'd0)
    else $error("select fell with clock not idle");

  cover property ($fell(sel_n_i));
  cover property ($fell(sclk_i) && nfall == 5'd15);
  cover property ($rose(sel_n_i));
endmodule

// File: testbench/tb_top.sv
// self-checking bench joining host and transceiver ends
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  addr      = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic        wr        = 1'b0;
  logic        rd        = 1'b0;
  logic        host_ce   = 1'b1;
  logic        dev_ce    = 1'b1;
  logic [31:0] rdata;
  logic [15:0] cw;
  logic        lna, txd, tst, bdv, sdv, lob, txb;
  logic [2:0]  asel, red;
  tscw_pkg::tscw_src_type amon;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  tscw_link_if link ();
  tscw_host u_tscw_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(host_ce), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
  tscw_device u_tscw_device (.link(link), .sys_rst_i(sys_rst_i), .ce_i(dev_ce), .control_word_o(cw),
    .lna_gain_reduce_o(lna), .tx_power_disable_o(txd), .analog_sel_o(asel), .analog_monitor_out_o(amon),
    .test_bits_set_o(tst), .big_divider_disable_o(bdv), .sixteen_divider_disable_o(sdv),
    .lo_buffer_high_power_o(lob), .tx_buffer_high_power_o(txb), .tx_power_reduce_o(red));
  tscw_link_chk u_tscw_link_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .sclk_i(link.sclk),
    .sdata_i(link.sdata), .sel_n_i(link.sel_n));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [15:0] exp_word(input logic [15:0] w);
    return w & ~tscw_pkg::TEST_BITS_MASK;
  endfunction

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_dev(input logic [15:0] e);
    chk({16'h0, cw}, {16'h0, e});
    chk({16'h0, lna, txd, asel, amon, tst, bdv, sdv, lob, txb, red},
      {16'h0, e[15], e[12], e[11], e[8], e[7], e[11], e[8], e[7], e[10] | e[9], e[6:0]});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // polls done, then clears it; a stuck frame shows as done never set
  task automatic wait_done;
    logic [31:0] s;
    s = 32'h0;
    for (int i = 0; i < 60 && s[tscw_pkg::STAT_DONE_BIT] !== 1'b1; i++) rd_reg(tscw_pkg::REG_STATUS, s);
    chk({31'h0, s[tscw_pkg::STAT_DONE_BIT]}, 32'h1);
    wr_reg(tscw_pkg::REG_STATUS, 32'h2);
  endtask

  task automatic send(input logic [15:0] w);
    wr_reg(tscw_pkg::REG_WORD, {16'h0, w});
    wr_reg(tscw_pkg::REG_CMD, 32'h1);
    wait_done();
    chk_dev(exp_word(w));
  endtask

  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    logic [31:0] r;
    logic [31:0] seed;
    logic [15:0] w;
    seed = 32'h8f23;
    repeat (20) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    chk_dev(tscw_pkg::WORD_RESET);
    rd_reg(tscw_pkg::REG_SENT, r);
    chk(r, {16'h0, tscw_pkg::WORD_RESET});
    rd_reg(8'h10, r);
    chk(r, 32'h0);
    wr_reg(8'h10, 32'hffff);
    rd_reg(tscw_pkg::REG_WORD, r);
    chk(r, {16'h0, tscw_pkg::WORD_RESET});
    $display("reset and map test done");
    for (int k = 0; k < 8; k++) begin
      w = 16'h0;
      {w[11], w[8], w[7]} = k[2:0];
      send(w);
    end
    send(16'hffff);
    $display("analog source and test bit test done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      send(seed[15:0]);
    end
    $display("random word test done");
    // a second start while busy must not restart or retarget the frame
    wr_reg(tscw_pkg::REG_WORD, 32'h1234);
    wr_reg(tscw_pkg::REG_CMD, 32'h1);
    rd_reg(tscw_pkg::REG_STATUS, r);
    chk(r, 32'h1);
    wr_reg(tscw_pkg::REG_WORD, 32'h00ff);
    wr_reg(tscw_pkg::REG_CMD, 32'h1);
    wait_done();
    chk_dev(exp_word(16'h1234));
    rd_reg(tscw_pkg::REG_SENT, r);
    chk(r, 32'h1034);
    rd_reg(tscw_pkg::REG_CMD, r);
    chk(r, 32'h0);
    $display("busy start test done");
    // a frozen host takes no start; a frozen transceiver ignores a whole frame
    @(posedge sys_clk_i);
    host_ce <= 1'b0;
    wr_reg(tscw_pkg::REG_CMD, 32'h1);
    @(posedge sys_clk_i);
    host_ce <= 1'b1;
    rd_reg(tscw_pkg::REG_STATUS, r);
    chk(r, 32'h0);
    @(posedge sys_clk_i);
    dev_ce <= 1'b0;
    wr_reg(tscw_pkg::REG_WORD, 32'h8001);
    wr_reg(tscw_pkg::REG_CMD, 32'h1);
    wait_done();
    chk_dev(exp_word(16'h1234));
    @(posedge sys_clk_i);
    dev_ce <= 1'b1;
    send(16'h8001);
    $display("clock enable test done");
    end_of_test();
  end
endmodule
